/* core/misc_control_instr_decode.sv */
// Decoder and executor of six miscellaneous single-cycle instructions with an APB register port.
`timescale 1ns/1ps
// Summary of operation
// - Word 0x29C decodes as watchdog disable; one word, one cycle, no carry, no skip.
// - Watchdog disable arms the stop; the stop happens at the next watchdog restart.
// - Interrupt enable instruction sets the interrupt enable flag to one.
// - Interrupts are accepted only one machine cycle after the enable instruction.
// - Word 0x05B arms power-down; only an immediately following power-down is valid.
// - Word 0x260 copies port zero input levels into the accumulator in one cycle.
module misc_control_instr_decode
  import misc_instr_pkg::*;
#(
  parameter logic [9:0] OP_WATCHDOG_RESTART = misc_instr_pkg::OP_WATCHDOG_RESTART_DEFAULT,
  parameter logic [9:0] OP_POWERDOWN        = misc_instr_pkg::OP_POWERDOWN_DEFAULT
) (
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [31:0]                       paddr,
  input  wire logic [31:0]                       pwdata,
  output logic      [31:0]                       prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  input  wire logic [misc_instr_pkg::INSTR_W-1:0] instr_word,
  input  wire logic                              instr_valid,
  input  wire logic [misc_instr_pkg::ACC_W-1:0]   input_port_zero,
  output misc_instr_pkg::core_state_t            core_state,
  output logic                                   powerdown_req
);
  import misc_instr_pkg::*;

  typedef enum logic [1:0] {APB_IDLE, APB_ANSWER} apb_state_t;

  apb_state_t          apb_state;
  logic [ACC_W-1:0]    port_meta;
  logic [ACC_W-1:0]    port_sync;
  logic [INSTR_W-1:0]  soft_instr;
  logic                soft_pending;
  logic                exec_valid;
  logic [INSTR_W-1:0]  exec_word;
  logic                write_hit;
  logic                instr_write;
  logic                events_clear;
  pd_events_t          events;
  logic                do_port_load;
  logic                do_int_enable;
  logic                do_wdt_disable;
  logic                do_wdt_restart;
  logic                do_pd_arm;
  logic                do_powerdown;

  function automatic logic addr_mapped(input logic [31:0] addr);
    addr_mapped = (addr == ADDR_STATUS) || (addr == ADDR_INSTR) || (addr == ADDR_EVENTS);
  endfunction : addr_mapped

  // One decode point per opcode keeps the executing blocks below in step with each other.
  function automatic logic op_hit(input logic valid, input logic [INSTR_W-1:0] word,
                                  input logic [INSTR_W-1:0] op);
    op_hit = valid && (word == op);
  endfunction : op_hit

  // Hardware instructions take the machine cycle; a software instruction waits for a free one.
  always_comb begin
    exec_valid = instr_valid | soft_pending;
    exec_word  = instr_valid ? instr_word : soft_instr;
  end

  // Unknown opcodes hit none of these and so pass as no-operations.
  always_comb begin
    do_port_load   = op_hit(exec_valid, exec_word, OP_PORT0_INPUT);
    do_int_enable  = op_hit(exec_valid, exec_word, OP_INTERRUPT_ENABLE);
    do_wdt_disable = op_hit(exec_valid, exec_word, OP_WATCHDOG_DISABLE);
    do_wdt_restart = op_hit(exec_valid, exec_word, OP_WATCHDOG_RESTART);
    do_pd_arm      = op_hit(exec_valid, exec_word, OP_POWERDOWN_ARM);
    do_powerdown   = op_hit(exec_valid, exec_word, OP_POWERDOWN);
  end

  assign write_hit    = psel & penable & pready & pwrite & ~pslverr;
  assign instr_write  = write_hit & (paddr == ADDR_INSTR);
  assign events_clear = write_hit & (paddr == ADDR_EVENTS);

  // The port pins are asynchronous to the core clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_meta <= ACC_RESET;
      port_sync <= ACC_RESET;
    end else begin
      port_meta <= input_port_zero;
      port_sync <= port_meta;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_instr   <= OP_NOP;
      soft_pending <= 1'b0;
    end else if (instr_write) begin
      soft_instr   <= pwdata[INSTR_W-1:0];
      soft_pending <= 1'b1;
    end else if (soft_pending && !instr_valid) begin
      soft_pending <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_state.accumulator <= ACC_RESET;
    end else if (do_port_load) begin
      core_state.accumulator <= port_sync;
    end
  end

  // The flag is set at once, but acceptance follows only at the next machine cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_state.interrupt_enable_flag <= 1'b0;
      core_state.interrupts_accepted   <= 1'b0;
    end else if (exec_valid) begin
      core_state.interrupts_accepted <= core_state.interrupt_enable_flag;
      if (do_int_enable) begin
        core_state.interrupt_enable_flag <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_state.watchdog_stop_armed <= 1'b0;
      core_state.watchdog_stopped    <= 1'b0;
    end else if (exec_valid) begin
      if (do_wdt_disable) begin
        core_state.watchdog_stop_armed <= 1'b1;
      end else if (do_wdt_restart && core_state.watchdog_stop_armed) begin
        core_state.watchdog_stopped    <= 1'b1;
        core_state.watchdog_stop_armed <= 1'b0;
      end
    end
  end

  // The qualifier lives for exactly one instruction, so any instruction in between voids it; idle cycles do not.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_state.powerdown_valid <= 1'b0;
      powerdown_req              <= 1'b0;
    end else begin
      powerdown_req <= 1'b0;
      if (exec_valid) begin
        core_state.powerdown_valid <= do_pd_arm;
        if (do_powerdown && core_state.powerdown_valid) begin
          powerdown_req <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_state.pending <= 1'b0;
    end else begin
      core_state.pending <= soft_pending;
    end
  end

  // Sticky event bits; a new event in the clearing cycle survives the clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      events <= '0;
    end else begin
      if (events_clear) begin
        events <= events & ~pd_events_t'(pwdata[1:0]);
      end
      if (do_powerdown) begin
        if (core_state.powerdown_valid) begin
          events.powerdown_count_hit <= 1'b1;
        end else begin
          events.powerdown_nop <= 1'b1;
        end
      end
    end
  end

  // Read data and the answer are registered in the setup cycle, so every access has no wait.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_state <= APB_IDLE;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= PRDATA_IDLE;
    end else begin
      case (apb_state)
        APB_IDLE: begin
          pready  <= 1'b0;
          pslverr <= 1'b0;
          prdata  <= PRDATA_IDLE;
          if (psel && !penable) begin
            apb_state <= APB_ANSWER;
            pready    <= 1'b1;
            pslverr   <= ~addr_mapped(paddr);
            if (!pwrite && paddr == ADDR_STATUS) begin
              prdata <= {22'h0, core_state};
            end else if (!pwrite && paddr == ADDR_EVENTS) begin
              prdata <= {30'h0, events};
            end
          end
        end
        APB_ANSWER: begin
          apb_state <= APB_IDLE;
          pready    <= 1'b0;
          pslverr   <= 1'b0;
          prdata    <= PRDATA_IDLE;
        end
        default: begin
          apb_state <= APB_IDLE;
          pready    <= 1'b0;
        end
      endcase
    end
  end

endmodule : misc_control_instr_decode

/* inc/misc_instr_pkg.sv */
// Package with opcodes, register map and carried types for the misc instruction decoder.
package misc_instr_pkg;

  localparam int          INSTR_W = 10;
  localparam int          ACC_W   = 4;

  localparam logic [9:0]  OP_WATCHDOG_DISABLE  = 10'h29C;
  localparam logic [9:0]  OP_INTERRUPT_ENABLE  = 10'h054;
  localparam logic [9:0]  OP_POWERDOWN_ARM     = 10'h05B;
  localparam logic [9:0]  OP_PORT0_INPUT       = 10'h260;
  // Opcodes of the restart and power-down instructions are not known here; defaults are arbitrary.
  localparam logic [9:0]  OP_WATCHDOG_RESTART_DEFAULT = 10'h3FE;
  localparam logic [9:0]  OP_POWERDOWN_DEFAULT        = 10'h3FD;
  localparam logic [9:0]  OP_NOP                      = 10'h000;

  localparam logic [31:0] ADDR_STATUS = 32'h0000_0000;
  localparam logic [31:0] ADDR_INSTR  = 32'h0000_0004;
  localparam logic [31:0] ADDR_EVENTS = 32'h0000_0008;

  localparam int          STATUS_ACC_LSB        = 0;
  localparam int          STATUS_INTERRUPT_ENABLE_FLAG_BIT       = 4;
  localparam int          STATUS_ACCEPT_BIT     = 5;
  localparam int          STATUS_WDT_ARMED_BIT  = 6;
  localparam int          STATUS_WDT_STOP_BIT   = 7;
  localparam int          STATUS_PD_VALID_BIT   = 8;
  localparam int          STATUS_PENDING_BIT    = 9;

  localparam logic [3:0]  ACC_RESET   = 4'h0;
  localparam logic [31:0] PRDATA_IDLE = 32'h0000_0000;

  typedef struct packed {
    logic              pending;
    logic              powerdown_valid;
    logic              watchdog_stopped;
    logic              watchdog_stop_armed;
    logic              interrupts_accepted;
    logic              interrupt_enable_flag;
    logic [ACC_W-1:0]  accumulator;
  } core_state_t;

  typedef struct packed {
    logic              powerdown_count_hit;
    logic              powerdown_nop;
  } pd_events_t;

endpackage : misc_instr_pkg

/* testbench/misc_decode_props.sv */
// Assertion checker for the miscellaneous instruction decoder, bound to its top module.
`timescale 1ns/1ps
module misc_decode_props
  import misc_instr_pkg::*;
#(
  parameter logic [9:0] OP_WATCHDOG_RESTART = OP_WATCHDOG_RESTART_DEFAULT,
  parameter logic [9:0] OP_POWERDOWN        = OP_POWERDOWN_DEFAULT
) (
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic [INSTR_W-1:0]         instr_word,
  input wire logic                       instr_valid,
  input wire logic [ACC_W-1:0]           input_port_zero,
  input wire misc_instr_pkg::core_state_t core_state,
  input wire logic                       powerdown_req
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire       v = instr_valid;
  wire [9:0] w = instr_word;
  wdt_arm_a: assert property (v && w == OP_WATCHDOG_DISABLE |=> core_state.watchdog_stop_armed)
    else $error("watchdog stop not armed");
  wdt_quiet_a: assert property (v && w == OP_WATCHDOG_DISABLE |=> $stable(core_state.accumulator))
    else $error("watchdog disable touched the accumulator");
  wdt_stop_a: assert property (v && w == OP_WATCHDOG_RESTART && core_state.watchdog_stop_armed
    |=> core_state.watchdog_stopped && !core_state.watchdog_stop_armed) else $error("watchdog not stopped");
  stop_sticky_a: assert property (core_state.watchdog_stopped |=> core_state.watchdog_stopped)
    else $error("watchdog stop was lost");
  flag_set_a: assert property (v && w == OP_INTERRUPT_ENABLE |=> core_state.interrupt_enable_flag)
    else $error("interrupt enable flag not set");
  accept_delay_a: assert property (v && w == OP_INTERRUPT_ENABLE && !core_state.interrupt_enable_flag
    |=> !core_state.interrupts_accepted) else $error("interrupts accepted too early");
  accept_next_a: assert property (v && core_state.interrupt_enable_flag
    |=> core_state.interrupts_accepted) else $error("interrupts not accepted after one cycle");
  pd_arm_a: assert property (v && w == OP_POWERDOWN_ARM |=> core_state.powerdown_valid)
    else $error("power-down qualifier not set");
  pd_clear_a: assert property (v && w != OP_POWERDOWN_ARM |=> !core_state.powerdown_valid)
    else $error("power-down qualifier outlived one instruction");
  pd_req_a: assert property (v && w == OP_POWERDOWN
    |=> powerdown_req == $past(core_state.powerdown_valid)) else $error("power-down request wrong");
  acc_load_a: assert property ($stable(input_port_zero)[*3] ##0 (v && w == OP_PORT0_INPUT)
    |=> core_state.accumulator == $past(input_port_zero)) else $error("accumulator not loaded from port");
  cover property (powerdown_req);
  cover property ($rose(core_state.interrupts_accepted));
  cover property ($rose(core_state.watchdog_stopped));
endmodule : misc_decode_props
bind misc_control_instr_decode misc_decode_props #(.OP_WATCHDOG_RESTART(OP_WATCHDOG_RESTART),
  .OP_POWERDOWN(OP_POWERDOWN)) props (.*);

/* testbench/tb.sv */
// Self-checking bench for the miscellaneous instruction decoder over APB and the instruction port.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tb;
  import misc_instr_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, instr_valid, powerdown_req;
  logic [31:0] paddr, pwdata, prdata, rdat;
  logic [9:0]  instr_word;
  logic [3:0]  input_port_zero;
  logic        rerr;
  core_state_t core_state;
  int          n_errors = 0, tests_run = 0, pd_seen = 0, cyc = 0;
  misc_control_instr_decode uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .instr_word(instr_word), .instr_valid(instr_valid),
    .input_port_zero(input_port_zero), .core_state(core_state), .powerdown_req(powerdown_req));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // Counting pulses at the edge keeps a one-cycle request from slipping past the sequence.
  always @(posedge pclk) begin
    if (powerdown_req === 1'b1) pd_seen <= pd_seen + 1;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("Checks run: %0d, mismatches: %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic exe(input logic [9:0] w);
    instr_word  <= w;
    instr_valid <= 1'b1;
    @(posedge pclk);
  endtask : exe
  task automatic idle(input int n);
    instr_valid <= 1'b0;
    repeat (n) @(posedge pclk);
  endtask : idle
  initial begin
    {psel, penable, pwrite, instr_valid} = 4'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    instr_word = OP_NOP;
    input_port_zero = 4'hA;
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK("reset status", 32'h0, rdat)
    apb(1'b0, 32'h0000_000C, 32'h0);
    `CHK("unmapped error", 1'b1, rerr)
    `CHK("unmapped data", 32'h0, rdat)
    exe(OP_PORT0_INPUT);
    idle(1);
    `CHK("port load", 4'hA, core_state.accumulator)
    input_port_zero <= 4'h5;
    apb(1'b1, ADDR_INSTR, {22'h0, OP_PORT0_INPUT});
    idle(2);
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK("soft port load", 32'h5, rdat)
    exe(OP_INTERRUPT_ENABLE);
    idle(1);
    `CHK("flag set", 1'b1, core_state.interrupt_enable_flag)
    `CHK("not yet accepted", 1'b0, core_state.interrupts_accepted)
    exe(OP_NOP);
    idle(1);
    `CHK("accepted", 1'b1, core_state.interrupts_accepted)
    exe(OP_WATCHDOG_DISABLE);
    idle(1);
    `CHK("stop armed", 2'b01, {core_state.watchdog_stopped, core_state.watchdog_stop_armed})
    exe(OP_WATCHDOG_RESTART_DEFAULT);
    idle(1);
    `CHK("stopped", 2'b10, {core_state.watchdog_stopped, core_state.watchdog_stop_armed})
    exe(OP_POWERDOWN_ARM);
    exe(OP_POWERDOWN_DEFAULT);
    idle(2);
    `CHK("qualified power-down", 1, pd_seen)
    exe(OP_POWERDOWN_ARM);
    exe(OP_NOP);
    exe(OP_POWERDOWN_DEFAULT);
    idle(2);
    `CHK("late power-down", 1, pd_seen)
    apb(1'b0, ADDR_EVENTS, 32'h0);
    `CHK("events", 32'h3, rdat)
    apb(1'b1, ADDR_EVENTS, 32'h3);
    apb(1'b0, ADDR_EVENTS, 32'h0);
    `CHK("events cleared", 32'h0, rdat)
    // A software instruction has to wait while the hardware stream fills every machine cycle.
    instr_word  <= OP_NOP;
    instr_valid <= 1'b1;
    apb(1'b1, ADDR_INSTR, {22'h0, OP_WATCHDOG_DISABLE});
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK("held soft instr", 2'b10, {rdat[STATUS_PENDING_BIT], rdat[STATUS_WDT_ARMED_BIT]})
    idle(2);
    // Status is read-only, so this write must leave every bit as it was.
    apb(1'b1, ADDR_STATUS, 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK("final status", 32'h0000_00F5, rdat)
    wrap_up();
  end
endmodule : tb
